// ===== design/cws_pkg.sv
package cws_pkg;

    localparam int unsigned CWS_WORD_W = 14;
    localparam int unsigned CWS_NARROW_W = 8;
    localparam int unsigned CWS_NUM_WORDS = 7;
    localparam int unsigned CWS_IDX_W = 3;

    // printed locations are not byte addresses: they are word indices
    localparam logic [15:0] CWS_IDX_VIN_GAIN = 16'h2085;
    localparam logic [15:0] CWS_IDX_VIN_OFFSET = 16'h2086;
    localparam logic [15:0] CWS_IDX_BUF_OFFSET = 16'h2087;
    localparam logic [15:0] CWS_IDX_DIFF_GAIN = 16'h2088;
    localparam logic [15:0] CWS_IDX_DIFF_OFFSET = 16'h2089;
    localparam logic [15:0] CWS_IDX_ADC_GAIN = 16'h208A;
    localparam logic [15:0] CWS_IDX_ADC_OFFSET = 16'h208B;

    localparam int unsigned CWS_ADDR_W = 18;
    localparam logic [CWS_ADDR_W-1:0] CWS_BASE_ADDR = {CWS_IDX_VIN_GAIN, 2'b00};

    // words whose upper six positions are unimplemented
    localparam logic [CWS_NUM_WORDS-1:0] CWS_NARROW_MASK = 7'h07;

    localparam logic [1:0] CWS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CWS_RESP_SLVERR = 2'h2;
    localparam logic [1:0] CWS_RESP_DECERR = 2'h3;

    // factory defaults: programmable cells erase to all ones
    localparam logic [CWS_WORD_W-1:0] CWS_ERASED_WORD = 14'h3FFF;

    typedef struct packed {
        logic valid;
        logic [1:0] resp;
    } cws_bresp_s;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [1:0] resp;
    } cws_rresp_s;

endpackage

// ===== design/cws_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

module cws_top
    import cws_pkg::*;
#(
    parameter logic [CWS_NUM_WORDS*CWS_WORD_W-1:0] CAL_INIT = {CWS_NUM_WORDS{CWS_ERASED_WORD}}
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CWS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CWS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [CWS_WORD_W-1:0] last_word
);

    // write channel: address and data latched independently, answer when both held
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic aw_rdy_q, aw_rdy_d;
    logic w_rdy_q, w_rdy_d;
    cws_bresp_s b_q, b_d;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        b_d = b_q;
        if (s_axi_awvalid && aw_rdy_q) begin
            aw_held_d = 1'b1;
        end
        if (s_axi_wvalid && w_rdy_q) begin
            w_held_d = 1'b1;
        end
        if (b_q.valid && s_axi_bready) begin
            b_d.valid = 1'b0;
        end
        if (aw_held_q && w_held_q && !b_q.valid) begin
            // every location here is read-only: writes are refused
            b_d.valid = 1'b1;
            b_d.resp = CWS_RESP_SLVERR;
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
        end
        aw_rdy_d = !aw_held_d && !b_d.valid;
        w_rdy_d = !w_held_d && !b_d.valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_rdy_q <= 1'b0;
            w_rdy_q <= 1'b0;
            b_q <= '0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            aw_rdy_q <= aw_rdy_d;
            w_rdy_q <= w_rdy_d;
            b_q <= b_d;
        end
    end

    // read channel
    logic ar_rdy_q, ar_rdy_d;
    cws_rresp_s r_q, r_d;
    logic [CWS_WORD_W-1:0] last_q, last_d;
    logic [CWS_ADDR_W-1:0] rel_addr;
    logic [CWS_IDX_W-1:0] rom_idx;
    logic [CWS_WORD_W-1:0] rom_word;
    logic addr_hit;

    assign rel_addr = s_axi_araddr - CWS_BASE_ADDR;
    assign addr_hit = (s_axi_araddr >= CWS_BASE_ADDR) && (s_axi_araddr[1:0] == 2'b00)
                      && (32'(rel_addr[CWS_ADDR_W-1:2]) < CWS_NUM_WORDS);
    assign rom_idx = rel_addr[2 +: CWS_IDX_W];

    cws_word_rom #(
        .CAL_INIT(CAL_INIT)
    ) u_rom (
        .idx(rom_idx),
        .word(rom_word)
    );

    always_comb begin
        r_d = r_q;
        last_d = last_q;
        if (r_q.valid && s_axi_rready) begin
            r_d.valid = 1'b0;
        end
        if (s_axi_arvalid && ar_rdy_q) begin
            r_d.valid = 1'b1;
            if (addr_hit) begin
                r_d.data = {{(32-CWS_WORD_W){1'b0}}, rom_word};
                r_d.resp = CWS_RESP_OKAY;
                last_d = rom_word;
            end else begin
                r_d.data = '0;
                r_d.resp = CWS_RESP_DECERR;
            end
        end
        ar_rdy_d = !r_d.valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_q <= 1'b0;
            r_q <= '0;
            last_q <= '0;
        end else begin
            ar_rdy_q <= ar_rdy_d;
            r_q <= r_d;
            last_q <= last_d;
        end
    end

    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bvalid = b_q.valid;
    assign s_axi_bresp = b_q.resp;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = r_q.valid;
    assign s_axi_rdata = r_q.data;
    assign s_axi_rresp = r_q.resp;
    // firmware-visible copy of the last word fetched, for trim loading
    assign last_word = last_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_good_read(logic [CWS_ADDR_W-1:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence

    a_vin_offset_read: assert property (s_good_read({CWS_IDX_VIN_OFFSET, 2'b00}) |=>
        s_axi_rvalid && s_axi_rdata[31:CWS_NARROW_W] == '0 && s_axi_rresp == CWS_RESP_OKAY)
        else $error("input-voltage offset read wrong");
    a_vin_gain_zero: assert property (s_good_read({CWS_IDX_VIN_GAIN, 2'b00}) |=>
        s_axi_rdata[31:CWS_NARROW_W] == '0 && s_axi_rdata[7:0] == CAL_INIT[7:0])
        else $error("input-voltage gain read wrong");
    a_vin_off_bits: assert property (s_good_read({CWS_IDX_VIN_OFFSET, 2'b00}) |=>
        s_axi_rdata[7:0] == CAL_INIT[CWS_WORD_W +: 8])
        else $error("input-voltage offset bits wrong");
    a_buffer_word: assert property (s_good_read({CWS_IDX_BUF_OFFSET, 2'b00}) |=>
        s_axi_rdata == {24'h000000, CAL_INIT[2*CWS_WORD_W +: 8]})
        else $error("buffer offset word wrong");
    a_diff_gain_word: assert property (s_good_read({CWS_IDX_DIFF_GAIN, 2'b00}) |=>
        s_axi_rdata == {18'h00000, CAL_INIT[3*CWS_WORD_W +: CWS_WORD_W]})
        else $error("diff gain word wrong");
    a_diff_off_word: assert property (s_good_read({CWS_IDX_DIFF_OFFSET, 2'b00}) |=>
        s_axi_rdata == {18'h00000, CAL_INIT[4*CWS_WORD_W +: CWS_WORD_W]})
        else $error("diff offset word wrong");
    a_adc_gain_word: assert property (s_good_read({CWS_IDX_ADC_GAIN, 2'b00}) |=>
        s_axi_rdata == {18'h00000, CAL_INIT[5*CWS_WORD_W +: CWS_WORD_W]})
        else $error("adc gain word wrong");
    a_adc_off_word: assert property (s_good_read({CWS_IDX_ADC_OFFSET, 2'b00}) |=>
        s_axi_rdata == {18'h00000, CAL_INIT[6*CWS_WORD_W +: CWS_WORD_W]} ##1
        last_word == CAL_INIT[6*CWS_WORD_W +: CWS_WORD_W])
        else $error("adc offset word wrong");
    a_write_refused: assert property (aw_held_q && w_held_q && !s_axi_bvalid |=>
        s_axi_bvalid && s_axi_bresp == CWS_RESP_SLVERR)
        else $error("write not refused");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");

    // a write is answered two cycles after its second half is taken, one cycle after both halves are held
    localparam int B_LAT_MIN = 1;
    localparam int B_LAT_MAX = 2;

    // window decoded afresh so the checks below do not lean on addr_hit
    logic rd_outside;
    assign rd_outside = (s_axi_araddr[1:0] != 2'b00) || (s_axi_araddr < CWS_BASE_ADDR)
                        || (s_axi_araddr > {CWS_IDX_ADC_OFFSET, 2'b00});

    sequence s_read_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_read_hit;
        s_read_take ##0 !rd_outside;
    endsequence

    sequence s_read_miss;
        s_read_take ##0 rd_outside;
    endsequence

    sequence s_read_answer(logic [1:0] code);
        s_axi_rvalid && s_axi_rresp == code;
    endsequence

    sequence s_write_take;
        (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
    endsequence

    a_read_answer: assert property (s_read_take |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered in the next cycle");

    a_hit_okay: assert property (s_read_hit |=>
        s_read_answer(CWS_RESP_OKAY))
        else $error("mapped read not answered okay");

    a_miss_decerr: assert property (s_read_miss |=>
        s_read_answer(CWS_RESP_DECERR) ##0 s_axi_rdata == '0)
        else $error("unmapped read not refused");

    a_miss_keeps_word: assert property (s_read_miss |=>
        $stable(last_word))
        else $error("unmapped read changed the last word");

    a_hit_sets_word: assert property (s_read_hit |=>
        last_word == s_axi_rdata[CWS_WORD_W-1:0])
        else $error("last word differs from the word returned");

    a_rdata_width: assert property (s_axi_rvalid |->
        s_axi_rdata[31:CWS_WORD_W] == '0)
        else $error("read data wider than a word");

    a_narrow_upper: assert property (
        s_read_hit ##0 s_axi_araddr < {CWS_IDX_DIFF_GAIN, 2'b00} |=>
        s_axi_rdata[CWS_WORD_W-1:CWS_NARROW_W] == '0)
        else $error("unimplemented bits of a narrow word set");

    a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        $stable(s_axi_rresp))
        else $error("read response changed while waiting");

    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed after the answer");

    a_one_read: assert property (s_axi_rvalid |->
        !s_axi_arready)
        else $error("second read taken while one is open");

    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");

    a_bresp_refuse: assert property (s_axi_bvalid |->
        s_axi_bresp == CWS_RESP_SLVERR)
        else $error("write answer not an error");

    a_b_after_pair: assert property ($rose(s_axi_bvalid) |->
        $past(aw_held_q) && $past(w_held_q))
        else $error("write answered before both halves arrived");

    a_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while an answer is open");

    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed after the answer");

    a_aw_taken_once: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready)
        else $error("write address ready stayed high");

    a_w_taken_once: assert property (s_axi_wvalid && s_axi_wready |=>
        !s_axi_wready)
        else $error("write data ready stayed high");

    a_no_store: assert property (
        s_write_take ##0 !(s_axi_arvalid && s_axi_arready) |=>
        $stable(last_word))
        else $error("refused write changed stored state");

    a_write_answer: assert property (
        (aw_held_q || (s_axi_awvalid && s_axi_awready)) && !s_axi_bvalid
        && (w_held_q || (s_axi_wvalid && s_axi_wready)) |->
        ##[B_LAT_MIN:B_LAT_MAX] s_axi_bvalid)
        else $error("write not answered in time");

    a_last_word_idle: assert property (!(s_axi_arvalid && s_axi_arready) |=>
        $stable(last_word))
        else $error("last word changed without a read");

endmodule

// ===== design/cws_word_rom.sv
`timescale 1ns/1ps

module cws_word_rom
    import cws_pkg::*;
#(
    parameter logic [CWS_NUM_WORDS*CWS_WORD_W-1:0] CAL_INIT = {CWS_NUM_WORDS{CWS_ERASED_WORD}}
) (
    input wire logic [CWS_IDX_W-1:0] idx,
    output logic [CWS_WORD_W-1:0] word
);

    logic [CWS_WORD_W-1:0] cells [CWS_NUM_WORDS];

    // unimplemented upper bits are forced to zero in the cell itself
    for (genvar g = 0; g < CWS_NUM_WORDS; g++) begin : g_cell
        if (CWS_NARROW_MASK[g]) begin : g_narrow
            assign cells[g] = {{(CWS_WORD_W-CWS_NARROW_W){1'b0}},
                               CAL_INIT[g*CWS_WORD_W +: CWS_NARROW_W]};
        end else begin : g_wide
            assign cells[g] = CAL_INIT[g*CWS_WORD_W +: CWS_WORD_W];
        end
    end

    always_comb begin
        word = '0;
        if (32'(idx) < CWS_NUM_WORDS) begin
            word = cells[idx];
        end
    end

endmodule

// ===== verification/calibration_word_store_test.sv
`timescale 1ns/1ps

module calibration_word_store_test;
    import cws_pkg::*;
    // narrow words carry set upper bits on purpose so the zero forcing is visible
    localparam logic [CWS_NUM_WORDS*CWS_WORD_W-1:0] CAL = {14'h2001, 14'h3FFF, 14'h2ABC,
        14'h1234, 14'h1F7F, 14'h2C80, 14'h3FA5};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [CWS_ADDR_W-1:0] awaddr = '0;
    logic [CWS_ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [CWS_WORD_W-1:0] last_word;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [CWS_ADDR_W-1:0] bad[5];
    logic [2:0] idx;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h7AA4E6C8;

    cws_top #(.CAL_INIT(CAL)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .last_word(last_word));

    initial begin
        forever #20 aclk = ~aclk;
    end

    function automatic logic [CWS_WORD_W-1:0] word_of(int k);
        word_of = CAL[k*CWS_WORD_W +: CWS_WORD_W];
        if (k < 3) word_of[13:8] = 6'h00;
    endfunction

    function automatic logic [CWS_ADDR_W-1:0] addr_of(int k);
        addr_of = CWS_BASE_ADDR + 18'(4 * k);
    endfunction

    function automatic logic [33:0] good_of(int k);
        good_of = {18'h00000, word_of(k), CWS_RESP_OKAY};
    endfunction

    task automatic report(string what, logic [33:0] exp, logic [33:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_rd(logic [33:0] e, logic [33:0] g);
        report("read data and response", e, g);
    endtask
    task automatic cmp_wr(logic [1:0] e, logic [1:0] g);
        report("write response", {32'h0, e}, {32'h0, g});
    endtask
    task automatic cmp_word(logic [CWS_WORD_W-1:0] e);
        report("last word", {20'h0, e}, {20'h0, last_word});
    endtask

    task automatic rd(input logic [CWS_ADDR_W-1:0] a, input logic [33:0] exp);
        rd_q.push_back(exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [CWS_ADDR_W-1:0] a, input logic [31:0] d);
        wr_q.push_back(CWS_RESP_SLVERR);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    // results are judged where they appear, in issue order
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) cmp_rd(rd_q.pop_front(), {rdata, rresp});
        if (bvalid === 1'b1 && bready) cmp_wr(wr_q.pop_front(), bresp);
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #400000;
        error_cnt++;
        $display("Error watchdog expired");
        end_sim();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp_word(14'h0000);
        for (int k = 0; k < 7; k++) begin
            rd(addr_of(k), good_of(k));
        end
        repeat (2) @(posedge aclk);
        cmp_word(word_of(6));
        $display("test word reads done");
        bad[0] = CWS_BASE_ADDR - 18'h4;
        bad[1] = CWS_BASE_ADDR + 18'h1;
        bad[2] = CWS_BASE_ADDR + 18'h2;
        bad[3] = CWS_BASE_ADDR + 18'h1C;
        bad[4] = CWS_BASE_ADDR + 18'h1C + 18'(4 * ($unsigned($random(seed)) % 64));
        foreach (bad[i]) rd(bad[i], {32'h0, CWS_RESP_DECERR});
        repeat (2) @(posedge aclk);
        cmp_word(word_of(6));
        $display("test unmapped reads done");
        for (int n = 0; n < 4; n++) begin
            idx = 3'($unsigned($random(seed)) % 7);
            wr(CWS_BASE_ADDR + 18'(4 * idx), $random(seed));
            rd(CWS_BASE_ADDR + 18'(4 * idx), {18'h00000, word_of(idx), CWS_RESP_OKAY});
        end
        $display("test refused writes done");
        repeat (3) @(posedge aclk);
        end_sim();
    end
endmodule
